// file: include/ccs_pkg.sv
// Shared constants, encodings and types for the cycle sequencer core
package ccs_pkg;
    // ----------------------------------------
    // Reset values and vectors
    // ----------------------------------------
    localparam logic [3:0] PH_RST = 4'h0;
    localparam logic [3:0] PH_ONE = 4'h1;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] RST_VEC = 16'hfffe;
    localparam logic [15:0] SWI_VEC = 16'hfffc;
    localparam logic [7:0] CCR_RST = 8'h68;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [1:0] STEP_RST = 2'h0;
    // Condition flag bit positions
    localparam int CCR_C = 0;
    localparam int CCR_Z = 1;
    localparam int CCR_N = 2;
    localparam int CCR_I = 3;
    localparam int CCR_H = 4;
    // Interrupt sources: index 0 is the software trap
    localparam int N_SRC = 128;
    localparam int IRQ_W = 7;
    // ----------------------------------------
    // Opcodes known to the control store
    // ----------------------------------------
    localparam logic [7:0] OP_XFER = 8'h97;
    localparam logic [7:0] OP_INCX = 8'h5c;
    localparam logic [7:0] OP_LDI = 8'ha6;
    localparam logic [7:0] OP_LDX1 = 8'he6;
    localparam logic [7:0] OP_MUL = 8'h42;
    localparam logic [7:0] OP_DIV = 8'h52;
    localparam logic [7:0] OP_DAA = 8'h72;
    localparam logic [7:0] OP_CLI = 8'h9a;
    localparam logic [7:0] OP_SEI = 8'h9b;
    localparam logic [7:0] OP_TRAP = 8'h83;
    // ----------------------------------------
    // Control word fields
    // ----------------------------------------
    typedef enum logic [2:0] {
        CAP_NONE = 3'h0, CAP_OPC = 3'h1, CAP_OPND = 3'h2,
        CAP_DATA = 3'h3, CAP_VECH = 3'h4, CAP_VECL = 3'h5
    } ccs_cap_type;
    typedef enum logic [2:0] {
        ISS_NONE = 3'h0, ISS_PC = 3'h1, ISS_IDX = 3'h2,
        ISS_VHI = 3'h3, ISS_VLO = 3'h4
    } ccs_iss_type;
    typedef enum logic [3:0] {
        EX_NONE = 4'h0, EX_XFER = 4'h1, EX_INCX = 4'h2, EX_LDI = 4'h3,
        EX_MUL = 4'h4, EX_DIV = 4'h5, EX_DAA = 4'h6, EX_CLI = 4'h7,
        EX_SEI = 4'h8, EX_TRAP = 4'h9
    } ccs_exe_type;
    typedef struct packed {
        ccs_cap_type cap;
        ccs_iss_type iss;
        ccs_exe_type exe;
        logic fin;
    } ccs_ctl_type;
    // First step of the vector entry, used straight out of reset
    localparam ccs_ctl_type CTL_RST = '{CAP_NONE, ISS_VHI, EX_TRAP, 1'b0};
endpackage

// file: rtl/ccs_sequencer.sv
// Four-phase cycle sequencer with opcode lookahead and interrupt entry
// Overview of operation
// - Timing from four one-cycle phase pulses.
// - Bus cycle is phase one through four.
// - Address driven no earlier than phase three.
// - Read data captured in next phase two.
// - Next state from held opcode and step.
// - Control store strobed once input stable.
// - Controls computed one cycle ahead.
// - One address formed per bus cycle.
// - Dedicated decimal, multiply and divide logic.
// - Every opcode prefetches, finite cycle count.
// - Lookahead copied to opcode register finally.
// - New opcode starts at next phase one.
// - Counter increments as prefetch proceeds.
// - Prefetch and final strobes per cycle.
// - Early prefetched opcode held until end.
// - Indexed load prefetches before final cycle.
// - Up to 128 sources including software trap.
// - Maskable requests only when mask clear.
// - Fixed priority, lowest source index first.
// - Source flag set/cleared by outside; acknowledged.
// - Reset and interrupts load vector into counter.
// - Requests sampled only in final cycle.
// - Accepted request forces trap opcode.
// - Forced trap saves decremented counter.
// - Reset loads counter from top vector.
module ccs_sequencer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Memory read port
    output logic [15:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    // Peripheral interrupt requests and acknowledge
    input wire logic [ccs_pkg::N_SRC-1:1] irq_pend,
    output logic irq_ack,
    output logic [ccs_pkg::IRQ_W-1:0] irq_ack_id,
    // Phase pulses
    output logic phase_one,
    output logic phase_two,
    output logic phase_three,
    output logic phase_four,
    // Sequencer status
    output logic prefetch_cycle_strobe,
    output logic final_cycle_strobe,
    output logic [7:0] instr_hold,
    output logic [15:0] trap_ret_pc,
    output logic [7:0] acc,
    output logic [7:0] cond_flags
);
    import ccs_pkg::*;

    logic [3:0] ph_r;
    logic p1, p2, p3, p4;
    ccs_ctl_type ctl_r, ctl_nxt;
    logic [1:0] step_r, seq_r;
    logic [7:0] ir_r, ir_nxt, look_r, opnd_r;
    logic [7:0] a_r, x_r, h_r, ccr_r;
    logic [15:0] pc_r, vec_r, ret_pc_r, addr_r, iss_addr;
    logic rd_r, forced_r, pre_r, fin_r, ack_r;
    logic [N_SRC-1:1] smp_r;
    logic irq_any, take;
    logic [IRQ_W-1:0] irq_win, ack_id_r;
    logic [7:0] daa_res, div_q, div_rem;
    logic daa_cy, div_err;
    logic [15:0] mul_res;

    // ----------------------------------------
    // Phase generator
    // ----------------------------------------
    // All phases idle in reset; the first edge after release gives phase one
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ph_r <= PH_RST;
        end else if (ph_r == PH_RST) begin
            ph_r <= PH_ONE;
        end else begin
            ph_r <= {ph_r[2:0], ph_r[3]};
        end
    end

    assign p1 = ph_r[0];
    assign p2 = ph_r[1];
    assign p3 = ph_r[2];
    assign p4 = ph_r[3];

    // ----------------------------------------
    // Control store
    // ----------------------------------------
    // Each step says what the arriving byte is and which address goes out next
    function automatic ccs_ctl_type cstore(input logic [7:0] op, input logic [1:0] st);
        ccs_ctl_type c;
        c = '{CAP_OPC, ISS_PC, EX_NONE, 1'b1};
        unique case (op)
            OP_XFER: c.exe = EX_XFER;
            OP_INCX: c.exe = EX_INCX;
            OP_MUL: c.exe = EX_MUL;
            OP_DIV: c.exe = EX_DIV;
            OP_DAA: c.exe = EX_DAA;
            OP_CLI: c.exe = EX_CLI;
            OP_SEI: c.exe = EX_SEI;
            OP_LDI: begin
                if (st == 2'h0) begin
                    c = '{CAP_OPND, ISS_PC, EX_NONE, 1'b0};
                end else begin
                    c.exe = EX_LDI;
                end
            end
            OP_LDX1: begin
                // Next opcode arrives in step 1, before the indexed data read
                unique case (st)
                    2'h0: c = '{CAP_OPND, ISS_PC, EX_NONE, 1'b0};
                    2'h1: c = '{CAP_OPC, ISS_IDX, EX_NONE, 1'b0};
                    default: c = '{CAP_DATA, ISS_PC, EX_NONE, 1'b1};
                endcase
            end
            OP_TRAP: begin
                unique case (st)
                    2'h0: c = CTL_RST;
                    2'h1: c = '{CAP_VECH, ISS_VLO, EX_NONE, 1'b0};
                    2'h2: c = '{CAP_VECL, ISS_PC, EX_NONE, 1'b0};
                    default: c = '{CAP_OPC, ISS_PC, EX_NONE, 1'b1};
                endcase
            end
            default: c.exe = EX_NONE; // Unknown opcodes behave as one-cycle no-ops
        endcase
        return c;
    endfunction

    // ----------------------------------------
    // Interrupt arbitration
    // ----------------------------------------
    // Lowest index wins; scan from the top so the last hit is the winner
    always_comb begin
        irq_any = 1'b0;
        irq_win = '0;
        for (int i = N_SRC - 1; i >= 1; i--) begin
            if (smp_r[i]) begin
                irq_any = 1'b1;
                irq_win = IRQ_W'(i);
            end
        end
    end

    // Requests are looked at only at the close of an instruction's last cycle
    assign take = p4 && ctl_r.fin && irq_any && !ccr_r[CCR_I];
    assign ir_nxt = ctl_r.fin ? (take ? OP_TRAP : look_r) : ir_r;
    assign ctl_nxt = cstore(ir_nxt, seq_r);

    // Sample in phase one so a late arrival waits for the next final cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            smp_r <= '0;
        end else if (p1) begin
            smp_r <= irq_pend;
        end
    end

    // Acknowledge pulse tells the source it was taken; it clears its own flag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            ack_id_r <= '0;
        end else begin
            ack_r <= take;
            if (take) begin
                ack_id_r <= irq_win;
            end
        end
    end

    // ----------------------------------------
    // Sequencer and opcode registers
    // ----------------------------------------
    // Next state settles in phase two; the store is strobed in phase four
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            seq_r <= STEP_RST;
            step_r <= STEP_RST;
            ctl_r <= CTL_RST;
            pre_r <= 1'b0;
            fin_r <= 1'b0;
        end else begin
            if (p2) begin
                seq_r <= ctl_r.fin ? STEP_RST : step_r + 2'h1;
            end
            if (p4) begin
                step_r <= seq_r;
                ctl_r <= ctl_nxt;
                pre_r <= (ctl_nxt.cap == CAP_OPC);
                fin_r <= ctl_nxt.fin;
            end
        end
    end

    // Opcode handover at the end of the last cycle; reset enters the vector flow
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ir_r <= OP_TRAP;
            vec_r <= RST_VEC;
            forced_r <= 1'b0;
        end else if (p4 && ctl_r.fin) begin
            ir_r <= ir_nxt;
            forced_r <= take;
            vec_r <= take ? SWI_VEC - {8'h00, irq_win, 1'b0} : SWI_VEC;
        end
    end

    // Bytes land in phase two of the cycle after their address went out
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            look_r <= REG_RST;
            opnd_r <= REG_RST;
        end else if (p2) begin
            if (ctl_r.cap == CAP_OPC) begin
                look_r <= mem_rdata;
            end
            if (ctl_r.cap == CAP_OPND) begin
                opnd_r <= mem_rdata;
            end
        end
    end

    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    // Counter steps past each opcode and operand byte, so it ends one past the lookahead
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pc_r <= PC_RST;
        end else if (p1 && ctl_r.exe == EX_TRAP && forced_r) begin
            pc_r <= pc_r - 16'h0001;
        end else if (p2) begin
            unique case (ctl_r.cap)
                CAP_OPC, CAP_OPND: pc_r <= pc_r + 16'h0001;
                CAP_VECH: pc_r[15:8] <= mem_rdata;
                CAP_VECL: pc_r[7:0] <= mem_rdata;
                default: pc_r <= pc_r;
            endcase
        end
    end

    // Return address latched after the forced decrement has taken effect
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ret_pc_r <= PC_RST;
        end else if (p3 && ctl_r.exe == EX_TRAP) begin
            ret_pc_r <= pc_r;
        end
    end

    // ----------------------------------------
    // Address issue
    // ----------------------------------------
    always_comb begin
        unique case (ctl_r.iss)
            ISS_IDX: iss_addr = {h_r, x_r} + {8'h00, opnd_r};
            ISS_VHI: iss_addr = vec_r;
            ISS_VLO: iss_addr = vec_r + 16'h0001;
            default: iss_addr = pc_r;
        endcase
    end

    // Read strobe stands from phase four until the capture in phase two
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr_r <= PC_RST;
            rd_r <= 1'b0;
        end else if (p3) begin
            if (ctl_r.iss != ISS_NONE) begin
                addr_r <= iss_addr;
            end
            rd_r <= (ctl_r.iss != ISS_NONE);
        end else if (p2) begin
            rd_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Execution registers
    // ----------------------------------------
    ccs_special_unit u_special (
        .a(a_r),
        .x(x_r),
        .h(h_r),
        .hc(ccr_r[CCR_H]),
        .cy(ccr_r[CCR_C]),
        .daa_res(daa_res),
        .daa_cy(daa_cy),
        .mul_res(mul_res),
        .div_q(div_q),
        .div_rem(div_rem),
        .div_err(div_err)
    );

    // Memory loads land in phase two, register operations act in phase three
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_r <= REG_RST;
            x_r <= REG_RST;
            h_r <= REG_RST;
            ccr_r <= CCR_RST;
        end else if (p2 && ctl_r.cap == CAP_DATA) begin
            a_r <= mem_rdata;
            ccr_r[CCR_Z] <= (mem_rdata == 8'h00);
            ccr_r[CCR_N] <= mem_rdata[7];
        end else if (p3) begin
            unique case (ctl_r.exe)
                EX_XFER: x_r <= a_r;
                EX_INCX: begin
                    x_r <= x_r + 8'h01;
                    ccr_r[CCR_Z] <= (x_r == 8'hff);
                end
                EX_LDI: begin
                    a_r <= opnd_r;
                    ccr_r[CCR_Z] <= (opnd_r == 8'h00);
                    ccr_r[CCR_N] <= opnd_r[7];
                end
                EX_MUL: begin
                    x_r <= mul_res[15:8];
                    a_r <= mul_res[7:0];
                    ccr_r[CCR_H] <= 1'b0;
                    ccr_r[CCR_C] <= 1'b0;
                end
                EX_DIV: begin
                    a_r <= div_q;
                    h_r <= div_rem;
                    ccr_r[CCR_C] <= div_err;
                end
                EX_DAA: begin
                    a_r <= daa_res;
                    ccr_r[CCR_C] <= daa_cy;
                end
                // Mask changes before the last-cycle sample of the same instruction
                EX_CLI: ccr_r[CCR_I] <= 1'b0;
                EX_SEI, EX_TRAP: ccr_r[CCR_I] <= 1'b1;
                default: ccr_r <= ccr_r;
            endcase
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign mem_addr = addr_r;
    assign mem_rd = rd_r;
    assign irq_ack = ack_r;
    assign irq_ack_id = ack_id_r;
    assign phase_one = ph_r[0];
    assign phase_two = ph_r[1];
    assign phase_three = ph_r[2];
    assign phase_four = ph_r[3];
    assign prefetch_cycle_strobe = pre_r;
    assign final_cycle_strobe = fin_r;
    assign instr_hold = ir_r;
    assign trap_ret_pc = ret_pc_r;
    assign acc = a_r;
    assign cond_flags = ccr_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    phase_order_a: assert property (p1 |=> p2 ##1 p3 ##1 p4 ##1 p1)
        else $error("phase order broken");
    addr_phase_a: assert property ($changed(addr_r) |-> $past(p3))
        else $error("address moved outside phase three");
    read_span_a: assert property (p3 && ctl_r.iss != ISS_NONE |=> rd_r [*3] ##1 !rd_r)
        else $error("read strobe span wrong");
    ctl_strobe_a: assert property ($changed(ctl_r) |-> $past(p4))
        else $error("control word changed outside phase four");
    ir_load_a: assert property ($changed(ir_r) |-> $past(p4 && ctl_r.fin) && p1)
        else $error("opcode register loaded off boundary");
    look_hold_a: assert property ($changed(look_r) |-> $past(p2 && ctl_r.cap == CAP_OPC))
        else $error("lookahead changed without prefetch");
    mask_gate_a: assert property (ack_r |-> !$past(ccr_r[CCR_I]) && ir_r == OP_TRAP)
        else $error("masked request accepted");
    pc_dec_a: assert property (p1 && ctl_r.exe == EX_TRAP && forced_r
        |-> ##3 ret_pc_r == $past(pc_r, 3) - 16'h0001)
        else $error("forced trap return address not decremented");
    prefetch_pc_a: assert property (p2 && ctl_r.cap == CAP_OPC
        |=> pc_r == $past(pc_r) + 16'h0001)
        else $error("counter did not step on prefetch");

    early_pref_c: cover property (pre_r && !fin_r && p1);
    irq_take_c: cover property (ack_r);
    vec_load_c: cover property (p2 && ctl_r.cap == CAP_VECL);
endmodule

// file: rtl/ccs_special_unit.sv
// Special-function arithmetic: decimal adjust, multiply and divide
module ccs_special_unit (
    // Operands
    input wire logic [7:0] a,
    input wire logic [7:0] x,
    input wire logic [7:0] h,
    input wire logic hc,
    input wire logic cy,
    // Results
    output logic [7:0] daa_res,
    output logic daa_cy,
    output logic [15:0] mul_res,
    output logic [7:0] div_q,
    output logic [7:0] div_rem,
    output logic div_err
);
    logic lo_fix;
    logic [7:0] dsr;
    logic [15:0] q16;
    logic [15:0] r16;

    // Decimal correction: add six to each nibble that left its range
    assign lo_fix = hc || (a[3:0] > 4'h9);
    assign daa_cy = cy || (a > 8'h99);
    assign daa_res = a + {(daa_cy ? 4'h6 : 4'h0), (lo_fix ? 4'h6 : 4'h0)};

    // Unsigned 8 by 8 product
    assign mul_res = {8'h00, a} * {8'h00, x};

    // Divisor of zero is replaced so the divider never sees it; err flags it
    assign dsr = (x == 8'h00) ? 8'h01 : x;
    assign q16 = {h, a} / {8'h00, dsr};
    assign r16 = {h, a} % {8'h00, dsr};
    assign div_q = q16[7:0];
    assign div_rem = r16[7:0];
    assign div_err = (x == 8'h00) || (q16[15:8] != 8'h00);
endmodule

// file: verification/ccs_mem_model.sv
// Behavioural memory bus partner for the cycle sequencer
module ccs_mem_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Read port
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata,
    // Answer speed
    input wire logic slow
);
    // ----------------------------------------
    // Storage and answer timing
    // ----------------------------------------
    logic [7:0] mem [0:65535];
    logic [1:0] cnt_r;
    logic [7:0] noise_r;

    // Blank memory reads as one-cycle no-ops
    initial begin
        foreach (mem[i]) mem[i] = 8'h01;
    end

    // Clocks since the strobe rose, and a pattern that churns every clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= 2'h0;
            noise_r <= 8'h3c;
        end else begin
            cnt_r <= mem_rd ? cnt_r + 2'h1 : 2'h0;
            noise_r <= noise_r + 8'h5b;
        end
    end

    // Slow answers land just before the capture edge; junk otherwise, so stale data never passes
    assign mem_rdata = (mem_rd && (!slow || cnt_r >= 2'h2)) ? mem[mem_addr] : noise_r;
endmodule

// file: verification/tb.sv
// Self-checking bench for the cycle sequencer core
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ccs_pkg::*;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic mclk, rst, slow, mem_rd, irq_ack, last_final, seen;
    logic phase_one, phase_two, phase_three, phase_four, prefetch_cycle_strobe, final_cycle_strobe;
    logic [15:0] mem_addr, trap_ret_pc, addr_prev, pf_addr, ret_exp;
    logic [7:0] mem_rdata, instr_hold, acc, cond_flags, pf_data, op_a, op_b, op_c;
    logic [N_SRC-1:1] irq_pend;
    logic [IRQ_W-1:0] irq_ack_id;
    logic [3:0] ph, ph_prev;
    logic [7:0] img [13];
    int fails, check_count, early, n, id2;
    assign ph = {phase_one, phase_two, phase_three, phase_four};

    ccs_sequencer ccs_sequencer_i (.mclk(mclk), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata), .irq_pend(irq_pend), .irq_ack(irq_ack), .irq_ack_id(irq_ack_id),
        .phase_one(phase_one), .phase_two(phase_two), .phase_three(phase_three), .phase_four(phase_four),
        .prefetch_cycle_strobe(prefetch_cycle_strobe), .final_cycle_strobe(final_cycle_strobe),
        .instr_hold(instr_hold), .trap_ret_pc(trap_ret_pc), .acc(acc), .cond_flags(cond_flags));
    ccs_mem_model ccs_mem_model_i (.mclk(mclk), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata), .slow(slow));

    // Vector address of a source and low byte of an unsigned product
    function automatic logic [15:0] vec_of(input int id);
        return SWI_VEC - 16'(2 * id);
    endfunction
    function automatic logic [7:0] exp_mul(input logic [7:0] a, input logic [7:0] b);
        return 8'(16'(a) * 16'(b));
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Watchdog, far beyond the fewer than two hundred clocks the program needs
    initial begin
        #40000;
        fails++;
        $display("[ERR] watchdog expected done seen hang");
        finish_test();
    end

    // Phase order, address timing, opcode handover; memory speed varies by the clock
    always @(negedge mclk) begin
        if (rst) begin
            ph_prev = 4'h0;
            last_final = 1'b0;
        end else begin
            slow <= 1'($urandom);
            chk("phase", {12'h0, (ph_prev == 4'h0) ? 4'h8 : {ph_prev[0], ph_prev[3:1]}}, {12'h0, ph});
            if (mem_addr !== addr_prev)
                chk("addr_edge", 16'h1, {15'h0, phase_four});
            if (phase_two && prefetch_cycle_strobe) begin
                pf_data = mem_rdata;
                pf_addr = mem_addr;
            end
            if (phase_one && last_final)
                chk("opcode", {8'h0, irq_ack ? OP_TRAP : pf_data}, {8'h0, instr_hold});
            if (phase_one && prefetch_cycle_strobe && !final_cycle_strobe)
                early++;
            if (phase_four)
                last_final = final_cycle_strobe;
            if (irq_ack)
                ret_exp = pf_addr;
            ph_prev = ph;
        end
        addr_prev = mem_addr;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h00ab));
        rst = 1'b1;
        slow = 1'b0;
        irq_pend = '0;
        fails = 0;
        check_count = 0;
        early = 0;
        op_a = 8'($urandom);
        op_b = 8'($urandom);
        op_c = 8'($urandom);
        id2 = 6 + int'($urandom % 122);
        #1;
        img = '{OP_LDI, 8'h50, OP_XFER, OP_LDX1, 8'h02, OP_INCX, OP_LDI, op_a, OP_XFER, OP_LDI, op_b, OP_MUL, OP_CLI};
        foreach (img[i]) ccs_mem_model_i.mem[16'(16'h0100 + i)] = img[i];
        ccs_mem_model_i.mem[16'h0052] = op_c;
        ccs_mem_model_i.mem[16'hfffe] = 8'h01;
        ccs_mem_model_i.mem[16'hffff] = 8'h00;
        ccs_mem_model_i.mem[vec_of(5)] = 8'h02;
        ccs_mem_model_i.mem[vec_of(5) + 16'h1] = 8'h00;
        ccs_mem_model_i.mem[vec_of(id2)] = 8'h02;
        ccs_mem_model_i.mem[vec_of(id2) + 16'h1] = 8'h00;
        ccs_mem_model_i.mem[16'h0200] = OP_CLI;
        repeat (10) @(negedge mclk);
        chk("rst_out", {8'h0, OP_TRAP}, {4'h0, ph, instr_hold});
        chk("rst_regs", {REG_RST, CCR_RST}, {acc, cond_flags});
        chk("rst_bus", 16'h0, mem_addr | {14'h0, mem_rd, irq_ack});
        // Non-blocking so the checker at this same falling edge still sees reset held
        rst <= 1'b0;
        irq_pend[5] = 1'b1;
        irq_pend[id2] = 1'b1;
        for (n = 0; n < 60 && !(phase_one && instr_hold !== OP_TRAP); n++) @(negedge mclk);
        chk("first_op", {8'h0, OP_LDI}, {8'h0, instr_hold});
        for (n = 0; n < 200 && instr_hold !== OP_INCX; n++) @(negedge mclk);
        repeat (4) @(negedge mclk);
        chk("ldx_acc", {8'h0, op_c}, {8'h0, acc});
        chk("early_pf", 16'h1, {15'h0, early > 0});
        for (n = 0; n < 400 && irq_ack !== 1'b1; n++) @(negedge mclk);
        chk("mul_acc", {8'h0, exp_mul(op_a, op_b)}, {8'h0, acc});
        chk("ack_id", 16'd5, {9'h0, irq_ack_id});
        irq_pend[5] = 1'b0;
        seen = 1'b0;
        for (n = 0; n < 16; n++) begin
            @(negedge mclk);
            if (mem_addr === vec_of(5))
                seen = 1'b1;
        end
        chk("vector", 16'h1, {15'h0, seen});
        chk("ret_pc", ret_exp, trap_ret_pc);
        chk("mask", 16'h1, {15'h0, cond_flags[CCR_I]});
        for (n = 0; n < 400 && irq_ack !== 1'b1; n++) @(negedge mclk);
        chk("ack_id2", 16'(id2), {9'h0, irq_ack_id});
        irq_pend[id2] = 1'b0;
        repeat (40) @(negedge mclk);
        finish_test();
    end
endmodule
